// ### rtl/sdio_consts.svh
// Constants for the stepper driver I/O control block
`ifndef SDIO_CONSTS_SVH
`define SDIO_CONSTS_SVH

// Clock and timing
`define SDIO_CLK_PERIOD_NS  4
`define SDIO_RAMP_TICK_NS   1000000
`define SDIO_STEP_CYCLES    250
`define SDIO_TIM_DIVISOR    16'h0032

// Current figures in units of 0.1 % of rated current
`define SDIO_RAMP_UP        10'h009
`define SDIO_RAMP_DOWN      10'h012
`define SDIO_PUSH_BASE      10'h12c
`define SDIO_PUSH_STEP      10'h064

// Register byte addresses
`define SDIO_ADDR_CTRL      8'h00
`define SDIO_ADDR_RES       8'h04
`define SDIO_ADDR_DEVLIM    8'h08
`define SDIO_ADDR_RUNCUR    8'h0c
`define SDIO_ADDR_STATUS    8'h10
`define SDIO_ADDR_CMDPOS    8'h14
`define SDIO_ADDR_CURRENT   8'h18

// Reset values
`define SDIO_CTRL_RST       1'h1
`define SDIO_RES_RST        16'h03e8
`define SDIO_DEVLIM_RST     16'h0005
`define SDIO_RUNCUR_RST     10'h1f4

// Status field positions
`define SDIO_ST_READY       0
`define SDIO_ST_EXCITE      1
`define SDIO_ST_WARN        2
`define SDIO_ST_HOMING      3
`define SDIO_ST_AUTORET     4
`define SDIO_ST_ALARM_LSB   8

`endif

// ### rtl/sdio_pkg.sv
// Types shared by the stepper driver I/O control block
`default_nettype none
package sdio_pkg;

  // Motion sequence currently in charge of the command
  typedef enum logic [2:0] {
    MV_IDLE = 3'b001,
    MV_HOME = 3'b010,
    MV_AUTO = 3'b100
  } sdio_move_e;

  // Active alarm code
  typedef enum logic [3:0] {
    AL_NONE     = 4'h0,
    AL_OVERLOAD = 4'h1,
    AL_MAINPWR  = 4'h2,
    AL_OPDATA   = 4'h3
  } sdio_alarm_e;

  // Whole state of the top module
  typedef struct packed {
    logic [15:0] prevIn;
    logic [31:0] cmdPos;
    logic [31:0] homePos;
    sdio_move_e  move;
    sdio_alarm_e alarm;
    logic        warnOpData;
    logic [9:0]  curPct;
    logic        ramping;
    logic [31:0] msCnt;
    logic [15:0] stepCnt;
    logic [15:0] timCnt;
    logic        timOut;
    logic        stepOut;
    logic        stepDir;
    logic        ready;
    logic        excite;
    logic        torqueLim;
    logic        posDone;
    logic        fault;
    logic        warnOut;
    logic        ctrlWarnEn;
    logic [15:0] resolution;
    logic [15:0] devLimit;
    logic [9:0]  runCur;
    logic        ahbWrite;
    logic [7:0]  ahbAddr;
    logic [31:0] rdData;
    logic        readyOut;
  } sdio_state_s;

endpackage
`default_nettype wire

// ### rtl/sdio_sync.sv
// Two-stage synchroniser for the discrete inputs
`default_nettype none
module sdio_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // Levels in and out
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  // First stage only feeds the second
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } sdio_sync_s;

  sdio_sync_s st;       // Registered stages
  sdio_sync_s next_st;  // Next stages

  if (W < 1) begin : g_chk
    $error("sdio_sync needs at least one bit");
  end

  // Shift each level one stage on
  always_comb begin
    next_st      = st;
    next_st.meta = asyncIn;
    next_st.held = st.meta;
  end

  // Stage registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign syncOut = st.held;

endmodule
`default_nettype wire

// ### rtl/sdio_top.sv
// Control and status logic of a pulse-input stepper driver
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`include "sdio_consts.svh"
`default_nettype none

module sdio_top
#(
  parameter int MS_CYCLES   = `SDIO_RAMP_TICK_NS / `SDIO_CLK_PERIOD_NS,
  parameter int STEP_CYCLES = `SDIO_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Step pulses from the controller
  input  wire logic        cwPulse,
  input  wire logic        ccwPulse,
  // Discrete control inputs
  input  wire logic        positionReset,
  input  wire logic        currentOn,
  input  wire logic        resolutionSelect,
  input  wire logic        pushMode,
  input  wire logic        pushCurrentSelectBit0,
  input  wire logic        pushCurrentSelectBit1,
  input  wire logic        pushCurrentSelectBit2,
  input  wire logic        faultResetInput,
  input  wire logic        deviationZeroInput,
  input  wire logic        freeRun,
  input  wire logic        homeReturn,
  // Power stage and motion core status
  input  wire logic        mainPowerOk,
  input  wire logic        overloadDetect,
  input  wire logic        speedCmdIdle,
  input  wire logic [31:0] motorPosition,
  // Outputs to the controller
  output logic             readyOutput,
  output logic             positioningComplete,
  output logic             torqueLimitOutput,
  output logic             phaseMarkerOutputLineDriver,
  output logic             phaseMarkerOutputOpenCollector,
  output logic             faultOutput,
  output logic             warningOutput,
  // Outputs to the power stage
  output logic             motorExcite,
  output logic             motorStep,
  output logic             motorStepDir,
  output logic [9:0]       motorCurrent,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  import sdio_pkg::*;

  if (MS_CYCLES < 1 || STEP_CYCLES < 2 || STEP_CYCLES > 65535) begin : g_chk
    $error("sdio_top timing parameters out of range");
  end

  localparam logic [31:0] MS_LAST   = 32'(MS_CYCLES - 1);
  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

  sdio_state_s st;       // Registered state
  sdio_state_s next_st;  // Next state
  logic [15:0] rawIn;    // Inputs before synchronising
  logic [15:0] syn;      // Synchronised input levels

  // Gather every discrete input for the synchroniser
  assign rawIn = {speedCmdIdle, overloadDetect, mainPowerOk, homeReturn,
                  freeRun, deviationZeroInput, faultResetInput,
                  pushCurrentSelectBit2, pushCurrentSelectBit1,
                  pushCurrentSelectBit0, pushMode, resolutionSelect,
                  currentOn, positionReset, ccwPulse, cwPulse};

  // Bring inputs into the clock domain
  sdio_sync #(
    .W (16)
  ) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .asyncIn (rawIn),
    .syncOut (syn)
  );

  // Next-state logic for the whole block
  always_comb begin
    logic [15:0]        rise;     // Rising edges of synced inputs
    logic [15:0]        fall;     // Falling edges of synced inputs
    logic signed [31:0] dev;      // Command minus actual position
    logic [31:0]        devMag;   // Magnitude of deviation
    logic               devOk;    // Deviation within limit
    logic [9:0]         target;   // Current the block aims at
    logic [15:0]        group;    // Pulses per phase marker
    logic               tick;     // One millisecond has passed
    logic               stepNow;  // Sequence step slot
    logic               noAlarm;  // No alarm stands
    rise    = syn & ~st.prevIn;
    fall    = ~syn & st.prevIn;
    dev     = $signed(st.cmdPos)
              - ($signed(motorPosition) - $signed(st.homePos));
    devMag  = dev[31] ? 32'(-dev) : 32'(dev);
    devOk   = devMag <= {16'h0000, st.devLimit};
    target  = syn[5] ? 10'(`SDIO_PUSH_BASE
                           + {7'h00, syn[8:6]} * `SDIO_PUSH_STEP)
                     : st.runCur;
    group   = st.resolution / `SDIO_TIM_DIVISOR;
    tick    = st.msCnt == MS_LAST;
    stepNow = st.stepCnt == STEP_LAST;
    noAlarm = st.alarm == AL_NONE;

    next_st         = st;
    next_st.prevIn  = syn;
    next_st.stepOut = 1'b0;
    next_st.timOut  = 1'b0;

    // Alarm cleared only on the off edge of fault reset
    if (fall[9]) begin
      next_st.alarm      = AL_NONE;
      next_st.warnOpData = 1'b0;
    end

    // Resolution select changed while current is on
    if ((rise[4] | fall[4]) && syn[3] && st.ctrlWarnEn) begin
      next_st.warnOpData = 1'b1;
    end

    // Overload only outside push mode
    if (syn[14] && !syn[5] && noAlarm) begin
      next_st.alarm = AL_OVERLOAD;
    end

    // Step pulse with main power cut
    if ((rise[0] | rise[1]) && !syn[13]) begin
      next_st.alarm = AL_MAINPWR;
    end

    // Normal pulse input, counted only while ready
    if (st.ready && syn[13] && (rise[0] ^ rise[1])) begin
      next_st.cmdPos  = rise[0] ? st.cmdPos + 32'h0000_0001
                                : st.cmdPos - 32'h0000_0001;
      next_st.stepOut = 1'b1;
      next_st.stepDir = rise[0];
      // Phase marker once per group of input pulses
      if (st.timCnt + 16'h0001 >= group) begin
        next_st.timCnt = 16'h0000;
        next_st.timOut = 1'b1;
      end else begin
        next_st.timCnt = st.timCnt + 16'h0001;
      end
    end

    // Sequence stepping timer runs only while a sequence moves
    if (st.move != MV_IDLE && st.excite) begin
      next_st.stepCnt = stepNow ? 16'h0000 : st.stepCnt + 16'h0001;
    end else begin
      next_st.stepCnt = 16'h0000;
    end

    // Motion sequences
    unique case (st.move)
      MV_IDLE: begin
        // Home request: warning escalates, else start homing
        if (rise[12]) begin
          if (st.warnOpData) begin
            next_st.alarm = AL_OPDATA;
          end else if (noAlarm && st.excite) begin
            next_st.move = MV_HOME;
          end
        end
        // Restored current or power with the motor displaced
        if ((rise[3] | rise[13]) && !devOk && noAlarm) begin
          next_st.move = MV_AUTO;
        end
      end
      MV_HOME: begin
        // Walk the command back to the electrical home
        if (stepNow && st.excite) begin
          if (st.cmdPos == 32'h0000_0000) begin
            if (devOk) begin
              next_st.move = MV_IDLE;
            end
          end else begin
            next_st.stepOut = 1'b1;
            next_st.stepDir = st.cmdPos[31];
            next_st.cmdPos  = st.cmdPos[31] ? st.cmdPos + 32'h0000_0001
                                            : st.cmdPos - 32'h0000_0001;
          end
        end
        // Current off interrupts; position is kept for resume
        if (!syn[3]) begin
          next_st.move = MV_IDLE;
        end
      end
      MV_AUTO: begin
        // Drive the motor back to the held command
        if (stepNow && st.excite) begin
          if (devOk) begin
            next_st.move = MV_IDLE;
          end else begin
            next_st.stepOut = 1'b1;
            next_st.stepDir = !dev[31];
          end
        end
      end
    endcase

    // Free run stops any sequence
    if (syn[11]) begin
      next_st.move = MV_IDLE;
    end

    // Deviation zero rebases the command; excitation is untouched
    if (syn[10]) begin
      next_st.cmdPos = motorPosition - st.homePos;
      next_st.move   = MV_IDLE;
    end

    // Position reset, refused while an alarm stands
    if (rise[2] && noAlarm) begin
      next_st.cmdPos  = 32'h0000_0000;
      next_st.homePos = motorPosition;
      if (st.move == MV_HOME) begin
        next_st.move = MV_IDLE;
      end
    end

    // A push edge starts a ramp; otherwise follow target at once
    if (rise[5] | fall[5]) begin
      next_st.ramping = 1'b1;
    end
    next_st.msCnt = (st.ramping && !tick) ? st.msCnt + 32'h0000_0001
                                          : 32'h0000_0000;
    if (!st.ramping && !(rise[5] | fall[5])) begin
      next_st.curPct = target;
    end else if (st.ramping && tick) begin
      if (st.curPct < target) begin
        // Rise toward the target current
        if (target - st.curPct <= `SDIO_RAMP_UP) begin
          next_st.curPct  = target;
          next_st.ramping = 1'b0;
        end else begin
          next_st.curPct = st.curPct + `SDIO_RAMP_UP;
        end
      end else begin
        // Fall toward the target current
        if (st.curPct - target <= `SDIO_RAMP_DOWN) begin
          next_st.curPct  = target;
          next_st.ramping = 1'b0;
        end else begin
          next_st.curPct = st.curPct - `SDIO_RAMP_DOWN;
        end
      end
    end

    // Excitation: operating-data alarm keeps the motor held
    next_st.excite = syn[3] && !syn[11] && syn[13]
                     && next_st.alarm != AL_OVERLOAD
                     && next_st.alarm != AL_MAINPWR;
    next_st.ready  = next_st.excite && next_st.alarm == AL_NONE
                     && next_st.move == MV_IDLE;

    // Torque limit by mode
    if (syn[5]) begin
      next_st.torqueLim = !st.ramping && st.curPct >= target;
    end else begin
      next_st.torqueLim = !devOk;
    end
    next_st.posDone = devOk && syn[15];
    next_st.fault   = next_st.alarm != AL_NONE;
    next_st.warnOut = next_st.warnOpData;

    // Bus data phase: apply a write captured last cycle
    if (st.ahbWrite) begin
      unique case (st.ahbAddr)
        `SDIO_ADDR_CTRL:   next_st.ctrlWarnEn = hwdata[0];
        `SDIO_ADDR_RES: begin
          // Only multiples of the marker divisor are accepted
          if (hwdata[15:0] != 16'h0000
              && hwdata[15:0] % `SDIO_TIM_DIVISOR == 16'h0000) begin
            next_st.resolution = hwdata[15:0];
          end
        end
        `SDIO_ADDR_DEVLIM: next_st.devLimit = hwdata[15:0];
        `SDIO_ADDR_RUNCUR: next_st.runCur   = hwdata[9:0];
        default: ;
      endcase
    end

    // Bus address phase: capture and prepare read data
    next_st.readyOut = 1'b1;
    next_st.ahbWrite = hsel && htrans[1] && hready && hwrite;
    next_st.ahbAddr  = {haddr[7:2], 2'b00};
    next_st.rdData   = 32'h0000_0000;
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case ({haddr[7:2], 2'b00})
        `SDIO_ADDR_CTRL:    next_st.rdData = {31'h0000_0000, st.ctrlWarnEn};
        `SDIO_ADDR_RES:     next_st.rdData = {16'h0000, st.resolution};
        `SDIO_ADDR_DEVLIM:  next_st.rdData = {16'h0000, st.devLimit};
        `SDIO_ADDR_RUNCUR:  next_st.rdData = {22'h00_0000, st.runCur};
        `SDIO_ADDR_STATUS: begin
          next_st.rdData[`SDIO_ST_READY]   = st.ready;
          next_st.rdData[`SDIO_ST_EXCITE]  = st.excite;
          next_st.rdData[`SDIO_ST_WARN]    = st.warnOpData;
          next_st.rdData[`SDIO_ST_HOMING]  = st.move == MV_HOME;
          next_st.rdData[`SDIO_ST_AUTORET] = st.move == MV_AUTO;
          next_st.rdData[`SDIO_ST_ALARM_LSB +: 4] = st.alarm;
        end
        `SDIO_ADDR_CMDPOS:  next_st.rdData = st.cmdPos;
        `SDIO_ADDR_CURRENT: next_st.rdData = {22'h00_0000, st.curPct};
        default:            next_st.rdData = 32'h0000_0000;
      endcase
    end
  end

  // State register; control fields get their defaults on reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st            <= '0;
      st.move       <= MV_IDLE;
      st.alarm      <= AL_NONE;
      st.ctrlWarnEn <= `SDIO_CTRL_RST;
      st.resolution <= `SDIO_RES_RST;
      st.devLimit   <= `SDIO_DEVLIM_RST;
      st.runCur     <= `SDIO_RUNCUR_RST;
      st.readyOut   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Every output except hresp straight from the state register; hresp is tied low
  assign readyOutput                    = st.ready;
  assign positioningComplete            = st.posDone;
  assign torqueLimitOutput              = st.torqueLim;
  assign phaseMarkerOutputLineDriver    = st.timOut;
  assign phaseMarkerOutputOpenCollector = st.timOut;
  assign faultOutput                    = st.fault;
  assign warningOutput                  = st.warnOut;
  assign motorExcite                    = st.excite;
  assign motorStep                      = st.stepOut;
  assign motorStepDir                   = st.stepDir;
  assign motorCurrent                   = st.curPct;
  assign hreadyout                      = st.readyOut;
  assign hresp                          = 1'b0;
  assign hrdata                         = st.rdData;

endmodule
`default_nettype wire

// ### verification/sdio_checker.sv
// Port assertions for the stepper driver control block
`include "sdio_consts.svh"
`default_nettype none
module sdio_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // Watched inputs
  input wire logic        cwPulse,
  input wire logic        ccwPulse,
  input wire logic        pushMode,
  input wire logic        pushCurrentSelectBit0,
  input wire logic        pushCurrentSelectBit1,
  input wire logic        pushCurrentSelectBit2,
  input wire logic        faultResetInput,
  input wire logic        speedCmdIdle,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  // Watched outputs
  input wire logic        readyOutput,
  input wire logic        positioningComplete,
  input wire logic        torqueLimitOutput,
  input wire logic        phaseMarkerOutputLineDriver,
  input wire logic        phaseMarkerOutputOpenCollector,
  input wire logic        faultOutput,
  input wire logic        motorExcite,
  input wire logic        motorStep,
  input wire logic        motorStepDir,
  input wire logic [9:0]  motorCurrent,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata
);
  logic [2:0] sel;     // Push current index, top input first
  assign sel = {pushCurrentSelectBit2, pushCurrentSelectBit1,
                pushCurrentSelectBit0};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // Excited push with a steady index
  sequence pushSettled;
    (pushMode && motorExcite && $stable(sel))[*6];
  endsequence
  // Clockwise edge taken while ready
  sequence cwAccepted;
    ($rose(cwPulse) && readyOutput && !ccwPulse) ##1
    (readyOutput && !ccwPulse)[*2];
  endsequence
  step_cw_dir_a: assert property (cwAccepted |=>
    motorStep && motorStepDir) else $error("cw step not issued");
  fault_not_ready_a: assert property (faultOutput[*2] |->
    !readyOutput) else $error("ready during fault");
  complete_idle_a: assert property ((!speedCmdIdle)[*4] |->
    !positioningComplete) else $error("complete while moving");
  phase_pair_a: assert property (phaseMarkerOutputLineDriver ==
    phaseMarkerOutputOpenCollector) else $error("phase lines differ");
  ramp_up_a: assert property (pushSettled ##0
    motorCurrent > $past(motorCurrent) |->
    motorCurrent - $past(motorCurrent) <= `SDIO_RAMP_UP)
    else $error("current rises too fast");
  ramp_down_a: assert property ((!pushMode && motorExcite)[*6]
    ##0 motorCurrent < $past(motorCurrent) |->
    $past(motorCurrent) - motorCurrent <= `SDIO_RAMP_DOWN)
    else $error("current falls too fast");
  push_level_a: assert property (pushSettled ##0
    torqueLimitOutput |-> motorCurrent ==
    `SDIO_PUSH_BASE + `SDIO_PUSH_STEP * {7'h0, sel})
    else $error("push current wrong");
  fault_hold_a: assert property (
    (faultOutput && faultResetInput)[*4] |=> faultOutput)
    else $error("alarm cleared on rising reset");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  rdata_idle_a: assert property (
    !$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
endmodule
bind sdio_top sdio_checker u_chk (.*);
`default_nettype wire

// ### verification/sdio_pulse_gen.sv
// Positioning controller model that sends trains of step pulses
`default_nettype none
module sdio_pulse_gen (
  // Clock
  input  wire logic       clk_sys,
  // Request from the bench
  input  wire logic       start,
  input  wire logic [7:0] count,
  input  wire logic       dir,
  // Step lines towards the driver, busy flag back to the bench
  output logic            cwPulse,
  output logic            ccwPulse,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left;  // Pulses still to send
  logic [1:0] phase; // One high slot, then three low slots
  initial begin
    cwPulse = 1'b0;
    ccwPulse = 1'b0;
    busy = 1'b0;
    left = 8'h0;
    phase = 2'h0;
  end
  // Lines idle low between pulses
  always @(posedge clk_sys) begin
    phase <= start ? 2'h0 : phase + 2'h1;
    if (start) begin
      left <= count;
      busy <= 1'b1;
    end else if (busy && phase == 2'h0) begin
      cwPulse <= dir && left != 8'h0;
      ccwPulse <= !dir && left != 8'h0;
      left <= (left == 8'h0) ? 8'h0 : left - 8'h1;
      busy <= left != 8'h0; // Train stops before any reset
    end else begin
      cwPulse <= 1'b0;
      ccwPulse <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the stepper driver control block
`include "sdio_consts.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20; // Shortened millisecond in cycles
  // Driver inputs
  logic        clk_sys = 1'b0, sys_rst = 1'b1, positionReset = 1'b0;
  logic        currentOn = 1'b1, resolutionSelect = 1'b0, pushMode = 1'b0;
  logic        faultResetInput = 1'b0, deviationZeroInput = 1'b0;
  logic        freeRun = 1'b0, homeReturn = 1'b0, mainPowerOk = 1'b1;
  logic        overloadDetect = 1'b0, speedCmdIdle = 1'b1;
  logic [2:0]  sel = 3'h0;
  logic [31:0] motorPosition = 32'h0;
  // Bus master and pulse generator controls
  logic        hsel = 1'b0, hwrite = 1'b0, pgStart = 1'b0, pgDir = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [7:0]  pgCount = 8'h0;
  // Outputs
  logic        pgBusy, cwPulse, ccwPulse, readyOutput, positioningComplete;
  logic        torqueLimitOutput, phLd, phOc, faultOutput, warningOutput;
  logic        motorExcite, motorStep, motorStepDir, hreadyout, hresp;
  logic [9:0]  motorCurrent;
  logic [31:0] hrdata;
  int          errors = 0, nTests = 0, nPhase = 0;
  always #2 clk_sys = ~clk_sys;
  sdio_top #(.MS_CYCLES(MS), .STEP_CYCLES(40)) dut (.clk_sys, .sys_rst,
    .cwPulse, .ccwPulse, .positionReset, .currentOn, .resolutionSelect,
    .pushMode, .pushCurrentSelectBit0(sel[0]), .pushCurrentSelectBit1(sel[1]),
    .pushCurrentSelectBit2(sel[2]), .faultResetInput, .deviationZeroInput,
    .freeRun, .homeReturn, .mainPowerOk, .overloadDetect, .speedCmdIdle,
    .motorPosition, .readyOutput, .positioningComplete, .torqueLimitOutput,
    .phaseMarkerOutputLineDriver(phLd), .phaseMarkerOutputOpenCollector(phOc),
    .faultOutput, .warningOutput, .motorExcite, .motorStep, .motorStepDir,
    .motorCurrent, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata);
  sdio_pulse_gen pg (.clk_sys, .start(pgStart), .count(pgCount), .dir(pgDir),
    .cwPulse, .ccwPulse, .busy(pgBusy));
  // Shaft follows every step a cycle later, so deviation stays within 1
  always @(posedge clk_sys) begin
    if (motorStep) motorPosition <= motorPosition +
      (motorStepDir ? 32'h1 : 32'hffff_ffff);
    if (phLd) nPhase++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    nTests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // One single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, string s);
    bus(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask
  // Pulse train from the controller model, then settle
  task automatic pulses(input logic [7:0] n, input logic d);
    pgStart <= 1'b1;
    pgCount <= n;
    pgDir <= d;
    @(posedge clk_sys) pgStart <= 1'b0;
    tick(1);
    for (int k = 0; k < 200 && pgBusy !== 1'b0; k++) @(posedge clk_sys);
    tick(6);
  endtask
  task automatic t_regs;
    logic [31:0] exp [4] = '{32'h1, 32'h3e8, 32'h5, 32'h1f4};
    for (int i = 0; i < 4; i++) rdChk(8'(4 * i), exp[i], "reset value");
    rdChk(8'h1c, 32'h0, "unmapped read");
    bus(1'b1, `SDIO_ADDR_RES, 32'h4b); // Not a multiple of 50
    rdChk(`SDIO_ADDR_RES, 32'h3e8, "refused resolution");
    bus(1'b1, `SDIO_ADDR_RES, 32'h64); // Two pulses a marker
    rdChk(`SDIO_ADDR_RES, 32'h64, "resolution");
  endtask
  task automatic t_steps;
    pulses(8'h5, 1'b1);
    rdChk(`SDIO_ADDR_CMDPOS, 32'h5, "count up");
    pulses(8'h2, 1'b0);
    rdChk(`SDIO_ADDR_CMDPOS, 32'h3, "count down");
    chk("phase markers", 32'h3, 32'(nPhase));
    chk("complete", 32'h1, 32'(positioningComplete));
    speedCmdIdle <= 1'b0;
    tick(6);
    chk("complete moving", 32'h0, 32'(positioningComplete));
    speedCmdIdle <= 1'b1;
  endtask
  task automatic t_home;
    homeReturn <= 1'b1;
    tick(6);
    rdChk(`SDIO_ADDR_STATUS, 32'ha, "homing");
    currentOn <= 1'b0;
    tick(6);
    rdChk(`SDIO_ADDR_STATUS, 32'h0, "homing cut");
    currentOn <= 1'b1;
    homeReturn <= 1'b0;
    tick(6);
    homeReturn <= 1'b1;
    tick(6);
    rdChk(`SDIO_ADDR_STATUS, 32'ha, "homing resumed");
    deviationZeroInput <= 1'b1;
    tick(6);
    rdChk(`SDIO_ADDR_STATUS, 32'h3, "homing cleared");
    deviationZeroInput <= 1'b0;
    homeReturn <= 1'b0;
    tick(6);
    homeReturn <= 1'b1;
    tick(6);
    positionReset <= 1'b1;
    tick(6);
    rdChk(`SDIO_ADDR_STATUS, 32'h3, "homing ended");
    rdChk(`SDIO_ADDR_CMDPOS, 32'h0, "home taken");
    positionReset <= 1'b0;
    homeReturn <= 1'b0;
    tick(6);
  endtask
  task automatic t_fault;
    pulses(8'h4, 1'b1);
    mainPowerOk <= 1'b0;
    tick(6);
    pulses(8'h1, 1'b1);
    chk("power fault", 32'h1, 32'(faultOutput));
    rdChk(`SDIO_ADDR_STATUS, 32'h200, "power alarm");
    rdChk(`SDIO_ADDR_CMDPOS, 32'h4, "step discarded");
    for (int r = 0; r < 2; r++) begin
      if (r == 1) begin
        mainPowerOk <= 1'b1;
        faultResetInput <= 1'b1;
        tick(8);
        chk("alarm held", 32'h1, 32'(faultOutput));
        faultResetInput <= 1'b0;
        tick(6);
        chk("alarm cleared", 32'h0, 32'(faultOutput));
      end
      tick(5 * MS); // Standstill before a reset
      positionReset <= 1'b1;
      tick(6);
      positionReset <= 1'b0;
      tick(6);
      rdChk(`SDIO_ADDR_CMDPOS, r ? 32'h0 : 32'h4, "reset");
    end // First pass runs under the alarm
  endtask
  task automatic t_warn;
    resolutionSelect <= 1'b1;
    tick(6);
    chk("data warning", 32'h1, 32'(warningOutput));
    homeReturn <= 1'b1;
    tick(6);
    bus(1'b0, `SDIO_ADDR_STATUS, 32'h0);
    chk("data alarm", 32'h3, {28'h0, q[11:8]});
    chk("still excited", 32'h1, 32'(motorExcite));
    homeReturn <= 1'b0;
    faultResetInput <= 1'b1;
    tick(6);
    faultResetInput <= 1'b0;
    tick(6);
    chk("alarm gone", 32'h0, 32'(faultOutput));
  endtask
  task automatic t_push;
    sel <= 3'h7;
    pushMode <= 1'b1;
    tick(10 * MS);
    chk("ramp up", 32'h1, 32'(motorCurrent > 10'h244 &&
      motorCurrent < 10'h258));
    chk("no limit yet", 32'h0, 32'(torqueLimitOutput));
    overloadDetect <= 1'b1;
    tick(50 * MS);
    chk("push top", 32'h3e8, 32'(motorCurrent));
    chk("limit", 32'h1, 32'(torqueLimitOutput));
    chk("overload off", 32'h0, 32'(faultOutput));
    overloadDetect <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      sel <= 3'(i);
      tick(6);
      chk("push level", 32'(300 + 100 * i), 32'(motorCurrent));
    end // Each index lands within a few cycles
    pushMode <= 1'b0;
    tick(10 * MS);
    chk("ramp down", 32'h1, 32'(motorCurrent > 10'h320 &&
      motorCurrent < 10'h348));
    tick(20 * MS);
    chk("run level", 32'h1f4, 32'(motorCurrent));
    overloadDetect <= 1'b1;
    tick(6);
    chk("overload on", 32'h1, 32'(faultOutput));
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Guard: about eight and a half times the run
  initial begin
    tick(20000);
    errors++;
    give_verdict;
  end
  initial begin
    tick(2);
    sys_rst <= 1'b0;
    tick(8);
    t_regs;
    t_steps;
    t_home;
    t_fault;
    t_warn;
    t_push;
    give_verdict;
  end
endmodule
`default_nettype wire
